/* File: rtl/charger_cfg_pkg.sv */
/*
  Shared constants for the port charger configuration bank: register
  offsets, reset values, write masks, field positions, durations and
  the emulation cycle states.
  Assumes a 250 MHz core clock.
*/
package charger_cfg_pkg;

  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0] GEN_OFS = 8'h15;
  localparam logic [7:0] EMU_OFS = 8'h16;
  localparam logic [7:0] SW_OFS = 8'h17;
  localparam logic [7:0] ATT_OFS = 8'h18;
  localparam logic [7:0] HSW_OFS = 8'h25;
  localparam logic [7:0] GEN_RST = 8'h01;
  localparam logic [7:0] EMU_RST = 8'h8C;
  localparam logic [7:0] SW_RST = 8'h04;
  localparam logic [7:0] ATT_RST = 8'h45;
  localparam logic [7:0] HSW_RST = 8'h14;

  // ==========================================================
  // Writable bits and bits that read back fixed
  localparam logic [7:0] GEN_WMASK = 8'hBF;
  localparam logic [7:0] EMU_WMASK = 8'h9F;
  localparam logic [7:0] SW_WMASK = 8'hBF;
  localparam logic [7:0] ATT_WMASK = 8'h0F;
  localparam logic [7:0] ATT_FIXED = 8'h40;
  localparam logic [7:0] HSW_WMASK = 8'h0F;
  localparam logic [7:0] HSW_FIXED = 8'h10;

  // ==========================================================
  // Field positions
  localparam int ALERT_MASK_BIT = 7;
  localparam int ALERT_LINK_BIT = 5;
  localparam int DISCHARGE_BIT = 4;
  localparam int BUDGET_EN_BIT = 3;
  localparam int BUDGET_RST_BIT = 2;
  localparam int BUDGET_BEH_LSB = 0;
  localparam int BUS_TO_DIS_BIT = 7;
  localparam int TIMER_DIS_BIT = 4;
  localparam int RESTART_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int RESET_SEL_LSB = 0;
  localparam int DRAIN_SEL_LSB = 2;
  localparam int ATTACH_THRESHOLD_SELECT_LSB = 0;
  localparam int HS_AFTER_BIT = 0;

  // ==========================================================
  // Durations in ms and clock rate
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CYC_PER_MS_DEF = CLK_MHZ * 1000;
  localparam int unsigned RESET_MS_0 = 50;
  localparam int unsigned RESET_MS_1 = 75;
  localparam int unsigned RESET_MS_2 = 125;
  localparam int unsigned RESET_MS_3 = 175;
  localparam int unsigned DRAIN_MS_0 = 100;
  localparam int unsigned DRAIN_MS_1 = 200;
  localparam int unsigned DRAIN_MS_2 = 300;
  localparam int unsigned DRAIN_MS_3 = 400;
  localparam int unsigned PROFILE_TIMER_MS = 1000;

  // ==========================================================
  // Profile order within the dedicated cycle
  localparam int NUM_PROFILES = 9;
  localparam logic [3:0] PRF_DCP = 4'h0;
  localparam logic [3:0] PRF_LG1 = 4'h1;
  localparam logic [3:0] PRF_LG2 = 4'h2;
  localparam logic [3:0] PRF_LG3 = 4'h3;
  localparam logic [3:0] PRF_CUSTOM = 4'h8;
  localparam logic [3:0] PRF_LAST = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_APPLY,
    S_ACCEPT,
    S_DRAIN,
    S_RESET,
    S_DONE
  } state_t;

endpackage

/* File: rtl/cycle_timer.sv */
/*
  Down-counting interval timer for the emulation cycle.
  Assumes load is a one-cycle request from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cycle_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] count;
    logic done;
  } tmr_t;

  tmr_t t_q;
  tmr_t t_d;

  // Count down; one-cycle pulse as the count leaves one
  always_comb
  begin
    t_d = t_q;
    t_d.done = 1'b0;
    if (load)
    begin
      t_d.count = load_value;
    end
    else if (t_q.count != '0)
    begin
      t_d.count = t_q.count - 1'b1;
      t_d.done = (t_q.count == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      t_q <= '0;
    else
      t_q <= t_d;
  end

  assign expired = t_q.done;

endmodule // cycle_timer
`default_nettype wire

/* File: rtl/port_charger_config_registers.sv */
/*
  Configuration bank of a USB port power controller: alert gating,
  forced VBUS discharge, charge budget, bus timeout control and the
  dedicated charger emulation cycle.
  Assumes the serial engine delivers whole bytes: reg_wr pulses once the
  final data bit of a write is accepted. Core inputs share clk; only the
  current comparator arrives asynchronously.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Alert mask bit 7 set keeps errors from asserting the alert.
// - Alert link bit 5 lets low-current or thermal flags assert alert.
// - Discharge bit 4 in Active opens switch and drains VBUS while set.
// - Budget enable low clears total, stops accumulating, clears flag.
// - Budget reset bit clears total and flag, releasing alert.
// - Two-bit behaviour field selects response once threshold reached.
// - Bus timeout disable bit 7 set turns serial timeouts off.
// - Profile timer disable bit 4 overrides the custom profile timer.
// - Timed profile held for timer period, then judged on expiry.
// - Untimed profile accepted as soon as charging current seen.
// - No restart: data outputs high-Z, switch closed, custom limiting.
// - Restart enabled: unaccepted cycle resets and restarts first profile.
// - Restart setting only matters in dedicated charger mode.
// - Hold off: response removed at timer expiry regardless of current.
// - Hold on: response kept until removal, thermal event or restart.
// - Held response is short for DCP/legacy 2, else driven voltages.
// - After-charger switch bit closes high-speed switch regardless of hold.
// - Reset duration field picks 50, 75, 125 or 175 ms.
// - Total reset interval is reset duration plus drain duration.
// - Register contents survive Sleep entry and exit.
// - Untimed acceptance of legacy 1, 3 or custom hides removal.
// - Drain time field picks 100, 200, 300 or 400 ms.
module port_charger_config_registers
  import charger_cfg_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
  parameter int unsigned PROFILE_MS = PROFILE_TIMER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic port_active,
  input wire logic dedicated_charger_cycle,
  input wire logic error_active,
  input wire logic low_current_flag,
  input wire logic thermal_regulation_flag,
  input wire logic thermal_regulation_flag_event,
  input wire logic removal_event,
  input wire logic [15:0] charge_sample,
  input wire logic charge_sample_valid,
  input wire logic [15:0] charge_threshold,
  input wire logic charging_current_pin,
  input wire logic [NUM_PROFILES-1:0] profile_enable,
  input wire logic custom_timer_enable,
  output logic alert_n,
  output logic port_switch_open,
  output logic vbus_drain_on,
  output logic bus_timeout_enable,
  output logic [15:0] charge_total,
  output logic charge_budget_flag,
  output logic [1:0] charge_budget_behaviour,
  output logic [3:0] profile_index,
  output logic profile_apply,
  output logic data_short_on,
  output logic data_drive_on,
  output logic data_out_hiz,
  output logic custom_limit_select,
  output logic hs_switch_close,
  output logic [7:0] switch_config,
  output logic [1:0] attach_threshold_select,
  output logic [3:0] hs_config
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] gen;
    logic [7:0] emu;
    logic [7:0] sw;
    logic [7:0] att;
    logic [7:0] hsw;
    logic [7:0] rdata;
    logic [2:0] sync;
    logic cur;
    state_t st;
    logic [3:0] idx;
    logic seen;
    logic timed;
    logic held;
    logic [15:0] acc;
    logic bflag;
    logic alert_n;
    logic sw_open;
    logic drain;
    logic short_on;
    logic drive_on;
    logic hiz;
    logic cust_lim;
    logic hs_close;
    logic apply;
    logic bto_en;
  } st_t;

  st_t s_q;
  st_t s_d;
  logic tmr_load;
  logic [31:0] tmr_val;
  logic tmr_exp;
  logic [16:0] sum;
  logic budget_clr;
  logic budget_set;
  logic timed_now;
  logic removal_ok;
  logic short_kind;
  logic [31:0] drain_cyc;
  logic [31:0] reset_cyc;

  cycle_timer #(.W(32)) i_cycle_timer (
    .clk(clk),
    .reset(reset),
    .load(tmr_load),
    .load_value(tmr_val),
    .expired(tmr_exp)
  );

  // ==========================================================
  // Duration decode
  always_comb
  begin
    case (s_q.att[DRAIN_SEL_LSB +: 2])
      2'h0: drain_cyc = 32'(DRAIN_MS_0 * CYC_PER_MS);
      2'h1: drain_cyc = 32'(DRAIN_MS_1 * CYC_PER_MS);
      2'h2: drain_cyc = 32'(DRAIN_MS_2 * CYC_PER_MS);
      default: drain_cyc = 32'(DRAIN_MS_3 * CYC_PER_MS);
    endcase
    case (s_q.emu[RESET_SEL_LSB +: 2])
      2'h0: reset_cyc = 32'(RESET_MS_0 * CYC_PER_MS);
      2'h1: reset_cyc = 32'(RESET_MS_1 * CYC_PER_MS);
      2'h2: reset_cyc = 32'(RESET_MS_2 * CYC_PER_MS);
      default: reset_cyc = 32'(RESET_MS_3 * CYC_PER_MS);
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    // Reset request acts for one cycle, then reads back zero
    s_d.gen[BUDGET_RST_BIT] = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        GEN_OFS: s_d.gen = reg_wdata & GEN_WMASK;
        EMU_OFS: s_d.emu = reg_wdata & EMU_WMASK;
        SW_OFS: s_d.sw = reg_wdata & SW_WMASK;
        ATT_OFS: s_d.att = (reg_wdata & ATT_WMASK) | ATT_FIXED;
        HSW_OFS: s_d.hsw = (reg_wdata & HSW_WMASK) | HSW_FIXED;
        default: s_d.sw = s_q.sw;
      endcase
    end
    case (reg_addr)
      GEN_OFS: s_d.rdata = s_q.gen;
      EMU_OFS: s_d.rdata = s_q.emu;
      SW_OFS: s_d.rdata = s_q.sw;
      ATT_OFS: s_d.rdata = s_q.att;
      HSW_OFS: s_d.rdata = s_q.hsw;
      default: s_d.rdata = 8'h00;
    endcase

    // Comparator input: three flops, change taken when last two agree
    s_d.sync = {s_q.sync[1:0], charging_current_pin};
    if (s_q.sync[2] == s_q.sync[1])
      s_d.cur = s_q.sync[2];

    budget_clr = !s_q.gen[BUDGET_EN_BIT] || s_q.gen[BUDGET_RST_BIT];
    sum = {1'b0, s_q.acc} + {1'b0, charge_sample};
    if (budget_clr)
      s_d.acc = 16'h0000;
    else if (charge_sample_valid)
      s_d.acc = sum[16] ? 16'hFFFF : sum[15:0];
    // reset clears flag, set wins
    // Judged on the new total, so a clear is not undone by the old one
    budget_set = s_q.gen[BUDGET_EN_BIT] && (s_d.acc >= charge_threshold);
    s_d.bflag = budget_set || (s_q.bflag && !budget_clr);

    // error gated by mask; budget flag asserts alert ungated
    s_d.alert_n = !((error_active && !s_q.gen[ALERT_MASK_BIT])
      || s_q.bflag
      || (s_q.gen[ALERT_LINK_BIT]
          && (low_current_flag || thermal_regulation_flag)));

    timed_now = !s_q.emu[TIMER_DIS_BIT]
      && ((s_q.idx != PRF_CUSTOM) || custom_timer_enable);
    // removal blind after untimed legacy 1/3/custom
    removal_ok = removal_event && !(s_q.st == S_ACCEPT && !s_q.timed
      && (s_q.idx == PRF_LG1 || s_q.idx == PRF_LG3
          || s_q.idx == PRF_CUSTOM));

    case (s_q.st)
      S_IDLE:
      begin
        if (dedicated_charger_cycle && port_active)
        begin
          s_d.st = S_APPLY;
          s_d.idx = PRF_DCP;
          s_d.seen = 1'b0;
          tmr_load = 1'b1;
          tmr_val = 32'(PROFILE_MS * CYC_PER_MS);
        end
      end
      S_APPLY:
      begin
        s_d.timed = timed_now;
        if (s_q.cur)
          s_d.seen = 1'b1;
        if (profile_enable[s_q.idx] && !timed_now && s_q.cur)
        begin
          s_d.st = S_ACCEPT;
          s_d.held = 1'b1;
        end
        else if (profile_enable[s_q.idx] && timed_now && tmr_exp
          && (s_q.seen || s_q.cur))
        begin
          s_d.st = S_ACCEPT;
          // no hold drops response at expiry
          s_d.held = s_q.emu[HOLD_BIT];
        end
        else if (!profile_enable[s_q.idx] || (timed_now && tmr_exp))
        begin
          if (s_q.idx == PRF_LAST)
          begin
            if (s_q.emu[RESTART_BIT])
            begin
              s_d.st = S_DRAIN;
              tmr_load = 1'b1;
              tmr_val = drain_cyc;
            end
            else
              s_d.st = S_DONE;
          end
          else
          begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.seen = 1'b0;
            tmr_load = 1'b1;
            tmr_val = 32'(PROFILE_MS * CYC_PER_MS);
          end
        end
      end
      S_ACCEPT:
      begin
        if (thermal_regulation_flag_event)
          s_d.held = 1'b0;
        if (removal_ok)
          s_d.st = S_IDLE;
      end
      S_DRAIN:
      begin
        if (tmr_exp)
        begin
          s_d.st = S_RESET;
          tmr_load = 1'b1;
          tmr_val = reset_cyc;
        end
      end
      S_RESET:
      begin
        if (tmr_exp)
        begin
          s_d.st = S_APPLY;
          s_d.idx = PRF_DCP;
          s_d.seen = 1'b0;
          tmr_load = 1'b1;
          tmr_val = 32'(PROFILE_MS * CYC_PER_MS);
        end
      end
      S_DONE:
      begin
        if (removal_ok)
          s_d.st = S_IDLE;
      end
      default: s_d.st = S_IDLE;
    endcase
    // cycle runs only in dedicated mode
    if (!dedicated_charger_cycle || !port_active)
      s_d.st = S_IDLE;

    // short for DCP and legacy 2, voltages otherwise
    short_kind = (s_q.idx == PRF_DCP) || (s_q.idx == PRF_LG2);
    s_d.apply = (s_q.st == S_APPLY) && profile_enable[s_q.idx];
    s_d.short_on = short_kind && (s_d.apply
      || (s_q.st == S_ACCEPT && s_q.held));
    s_d.drive_on = !short_kind && (s_d.apply
      || (s_q.st == S_ACCEPT && s_q.held));
    s_d.hiz = (s_q.st == S_DONE);
    s_d.cust_lim = (s_q.st == S_DONE);
    s_d.sw_open = (s_q.gen[DISCHARGE_BIT] && port_active)
      || (s_q.st == S_DRAIN);
    s_d.drain = s_d.sw_open;
    // after-charger closes switch regardless of hold
    s_d.hs_close = (s_q.st == S_ACCEPT) && port_active
      && s_q.hsw[HS_AFTER_BIT];
    // timeout on only when bit clear
    s_d.bto_en = !s_d.emu[BUS_TO_DIS_BIT];
  end

  // ==========================================================
  // Registers; no sleep input, so contents survive Sleep
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.gen <= GEN_RST;
      s_q.emu <= EMU_RST;
      s_q.sw <= SW_RST;
      s_q.att <= ATT_RST;
      s_q.hsw <= HSW_RST;
      s_q.alert_n <= 1'b1;
      s_q.bto_en <= !EMU_RST[BUS_TO_DIS_BIT];
      s_q.st <= S_IDLE;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign reg_rdata = s_q.rdata;
  assign alert_n = s_q.alert_n;
  assign port_switch_open = s_q.sw_open;
  assign vbus_drain_on = s_q.drain;
  // Registered copy keeps the pin free of gates
  assign bus_timeout_enable = s_q.bto_en;
  assign charge_total = s_q.acc;
  assign charge_budget_flag = s_q.bflag;
  assign charge_budget_behaviour = s_q.gen[BUDGET_BEH_LSB +: 2];
  assign profile_index = s_q.idx;
  assign profile_apply = s_q.apply;
  assign data_short_on = s_q.short_on;
  assign data_drive_on = s_q.drive_on;
  assign data_out_hiz = s_q.hiz;
  assign custom_limit_select = s_q.cust_lim;
  assign hs_switch_close = s_q.hs_close;
  assign switch_config = s_q.sw;
  assign attach_threshold_select = s_q.att[ATTACH_THRESHOLD_SELECT_LSB +: 2];
  assign hs_config = s_q.hsw[3:0];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_alert_mask: assert property (
    error_active && !s_q.gen[ALERT_MASK_BIT] |=> !alert_n)
    else $error("unmasked error did not assert alert");
  a_alert_link: assert property (
    !s_q.gen[ALERT_LINK_BIT] && !error_active && !s_q.bflag
    |=> alert_n)
    else $error("unlinked indicator asserted alert");
  a_force_drain: assert property (
    s_q.gen[DISCHARGE_BIT] && port_active |=> port_switch_open)
    else $error("discharge bit did not open switch");
  a_budget_off: assert property (
    !s_q.gen[BUDGET_EN_BIT]
    |=> charge_total == 16'h0000 && !$rose(charge_budget_flag))
    else $error("disabled budget kept its total");
  a_budget_clear: assert property (
    s_q.gen[BUDGET_RST_BIT] |=> charge_total == 16'h0000)
    else $error("budget reset did not clear total");
  a_bus_timeout: assert property (
    bus_timeout_enable == !s_q.emu[BUS_TO_DIS_BIT])
    else $error("bus timeout enable wrong");
  a_no_restart: assert property (
    $rose(s_q.st == S_DONE) |-> !$past(s_q.emu[RESTART_BIT]) ##1 data_out_hiz)
    else $error("cycle finished wrongly");
  a_restart_first: assert property (
    s_q.st == S_RESET && tmr_exp && dedicated_charger_cycle && port_active
    |=> s_q.st == S_APPLY && s_q.idx == PRF_DCP)
    else $error("restart did not begin at first profile");
  a_mode_gate: assert property (
    !dedicated_charger_cycle |=> s_q.st == S_IDLE)
    else $error("cycle ran outside dedicated mode");
  a_write_lands: assert property (
    reg_wr && reg_addr == EMU_OFS
    |=> s_q.emu == ($past(reg_wdata) & EMU_WMASK))
    else $error("write did not land next cycle");
  a_fixed_bits: assert property (
    s_q.att[7:4] == ATT_FIXED[7:4] && s_q.hsw[7:4] == HSW_FIXED[7:4])
    else $error("fixed bits changed");

  c_accept: cover property (s_q.st == S_APPLY ##1 s_q.st == S_ACCEPT);
  c_done: cover property (s_q.st == S_APPLY ##1 s_q.st == S_DONE);
  c_reset: cover property (s_q.st == S_DRAIN ##1 s_q.st == S_RESET);
  c_budget: cover property ($rose(charge_budget_flag));

endmodule // port_charger_config_registers
`default_nettype wire

/* File: bench/host_model.sv */
/*
  Serial host model: hands whole bytes to the register port.
  Assumes the port takes a write on the reg_wr edge and shows read data
  one cycle after the address is presented.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic rd_seen
);
  // ==========================================================
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    rd_seen = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Stale byte must not be reused
  endtask

  // Address held until the answer is taken
  task automatic read(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    rd_seen <= 1'b1;
    @(posedge clk);
    rd_seen <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

/* File: bench/port_charger_config_registers_tb_top.sv */
/*
  Self-checking bench for the charger configuration bank.
  Assumes host_model drives the register port; timers are shortened.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module port_charger_config_registers_tb_top
  import charger_cfg_pkg::*;
;
  typedef struct packed {logic [3:0] s; logic [15:0] v;} note_t;
  localparam int unsigned CPM = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, switch_config;
  logic reg_wr, rd_seen, probe = 1'b0, meas_ok = 1'b0;
  logic port_active = 1'b0, dedicated_charger_cycle = 1'b0;
  logic error_active = 1'b0, low_current_flag = 1'b0;
  logic thermal_regulation_flag = 1'b0, thermal_regulation_flag_event = 1'b0;
  logic removal_event = 1'b0, charge_sample_valid = 1'b0;
  logic charging_current_pin = 1'b0, custom_timer_enable = 1'b0;
  logic [15:0] charge_sample = 16'h0000, charge_threshold = 16'hFFFF;
  logic [NUM_PROFILES-1:0] profile_enable = 9'h001;
  logic alert_n, port_switch_open, vbus_drain_on, bus_timeout_enable;
  logic charge_budget_flag, profile_apply, data_short_on, data_drive_on;
  logic data_out_hiz, custom_limit_select, hs_switch_close;
  logic [15:0] charge_total, smp;
  logic [1:0] charge_budget_behaviour, attach_threshold_select;
  logic [3:0] profile_index, hs_config;
  note_t q[$];
  note_t nt;
  int errors = 0, check_count = 0, n, sum, ex;
  logic [7:0] ofs [6] = '{GEN_OFS, EMU_OFS, SW_OFS, ATT_OFS, HSW_OFS, 8'h1A};
  logic [7:0] rst [6] = '{GEN_RST, EMU_RST, SW_RST, ATT_RST, HSW_RST, 8'h00};
  logic [7:0] wm [6] = '{GEN_WMASK, EMU_WMASK, SW_WMASK, ATT_WMASK,
    HSW_WMASK, 8'h00};
  logic [7:0] fx [6] = '{8'h00, 8'h00, 8'h00, ATT_FIXED, HSW_FIXED, 8'h00};
  int rms [4] = '{RESET_MS_0, RESET_MS_1, RESET_MS_2, RESET_MS_3};

  always #2 clk = ~clk;

  // ==========================================================
  // Design and host
  port_charger_config_registers #(.CYC_PER_MS(CPM), .PROFILE_MS(2))
  i_port_charger_config_registers (.clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rdata, .port_active, .dedicated_charger_cycle,
    .error_active, .low_current_flag, .thermal_regulation_flag, .thermal_regulation_flag_event,
    .removal_event, .charge_sample, .charge_sample_valid, .charge_threshold,
    .charging_current_pin, .profile_enable, .custom_timer_enable, .alert_n,
    .port_switch_open, .vbus_drain_on, .bus_timeout_enable, .charge_total,
    .charge_budget_flag, .charge_budget_behaviour, .profile_index,
    .profile_apply, .data_short_on, .data_drive_on, .data_out_hiz,
    .custom_limit_select, .hs_switch_close, .switch_config,
    .attach_threshold_select, .hs_config);
  host_model i_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .rd_seen);

  // Output selector shared by monitor and waits
  function automatic logic [15:0] sig(input logic [3:0] s);
    case (s)
      4'h0: sig = {8'h00, reg_rdata};
      4'h1: sig = {15'h0000, alert_n};
      4'h2: sig = {14'h0000, port_switch_open, vbus_drain_on};
      4'h3: sig = {15'h0000, bus_timeout_enable};
      4'h4: sig = charge_total;
      4'h5: sig = {15'h0000, charge_budget_flag};
      4'h6: sig = {14'h0000, charge_budget_behaviour};
      4'h7: sig = {15'h0000, data_short_on};
      4'h8: sig = {13'h0000, data_out_hiz, port_switch_open,
        custom_limit_select};
      4'h9: sig = {15'h0000, profile_apply};
      4'hA: sig = {15'h0000, vbus_drain_on};
      4'hC: sig = {2'h0, hs_config, attach_threshold_select, switch_config};
      4'hD: sig = {10'h000, profile_index, data_drive_on, hs_switch_close};
      default: sig = {15'h0000, meas_ok};
    endcase
  endfunction

  // ==========================================================
  // Monitor: oldest note against the settled output
  always @(posedge clk)
  begin
    if (rd_seen || probe)
    begin
      nt = q.pop_front();
      `CHK(sig(nt.s), nt.v)
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic expect_out(input logic [3:0] s, input logic [15:0] v);
    repeat (3) @(posedge clk);
    q.push_back('{s, v});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    q.push_back('{4'h0, {8'h00, v}});
    i_host_model.read(a);
  endtask

  // Bounded wait; n returns the cycles spent
  task automatic wait_for(input logic [3:0] s, input logic [15:0] v,
    input int lim);
    n = 0;
    while (sig(s) !== v && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      complete_run();
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hC5F14BCE));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(ofs[i], rst[i]);
    expect_out(4'h3, 16'h0000);
    expect_out(4'hC, {2'h0, HSW_RST[3:0], ATT_RST[1:0], SW_RST});
    expect_out(4'h1, 16'h0001);
    // Budget reset bit reads back clear once it has acted
    for (int i = 0; i < 6; i++)
    begin
      i_host_model.write(ofs[i], 8'hFF);
      rd(ofs[i], ((wm[i] | fx[i]) & ((i == 0) ? 8'hFB : 8'hFF)));
      i_host_model.write(ofs[i], 8'h00);
      rd(ofs[i], fx[i]);
    end
    expect_out(4'h3, 16'h0001);
    error_active <= 1'b1;
    expect_out(4'h1, 16'h0000);
    i_host_model.write(GEN_OFS, 8'h80);
    expect_out(4'h1, 16'h0001);
    error_active <= 1'b0;
    low_current_flag <= 1'b1;
    i_host_model.write(GEN_OFS, 8'h20);
    expect_out(4'h1, 16'h0000);
    i_host_model.write(GEN_OFS, 8'h00);
    expect_out(4'h1, 16'h0001);
    low_current_flag <= 1'b0;
    port_active <= 1'b1;
    i_host_model.write(GEN_OFS, 8'h10);
    expect_out(4'h2, 16'h0003);
    i_host_model.write(GEN_OFS, 8'h00);
    expect_out(4'h2, 16'h0000);
    // Samples kept below 4096 so the sum cannot saturate
    i_host_model.write(GEN_OFS, 8'h08);
    sum = 0;
    for (int i = 0; i < 4; i++)
    begin
      smp = 16'($urandom_range(4095));
      sum += smp;
      @(posedge clk);
      charge_sample <= smp;
      charge_sample_valid <= 1'b1;
    end
    @(posedge clk);
    charge_sample_valid <= 1'b0;
    expect_out(4'h4, 16'(sum));
    i_host_model.write(GEN_OFS, 8'h0C);
    expect_out(4'h4, 16'h0000);
    for (int i = 0; i < 2; i++)
    begin
      charge_threshold <= 16'h0010;
      charge_sample <= 16'h0020;
      charge_sample_valid <= 1'b1;
      @(posedge clk);
      charge_sample_valid <= 1'b0;
      expect_out(4'h5, 16'h0001);
      expect_out(4'h1, 16'h0000);
      i_host_model.write(GEN_OFS, (i == 0) ? 8'h0C : 8'h00);
      expect_out(4'h5, 16'h0000);
      expect_out(4'h1, 16'h0001);
    end
    expect_out(4'h4, 16'h0000);
    for (int b = 0; b < 4; b++)
    begin
      i_host_model.write(GEN_OFS, 8'(b));
      expect_out(4'h6, 16'(b));
    end
    // Failed profile: drain, then reset interval, then restart
    for (int k = 0; k < 4; k++)
    begin
      i_host_model.write(EMU_OFS, 8'h08 | 8'(k));
      dedicated_charger_cycle <= 1'b1;
      wait_for(4'hA, 16'h0001, 3000);
      wait_for(4'h9, 16'h0001, 6000);
      ex = int'((rms[k] + DRAIN_MS_0) * CPM);
      meas_ok <= (n >= ex - 6) && (n <= ex + 6);
      expect_out(4'hB, 16'h0001);
      dedicated_charger_cycle <= 1'b0;
      repeat (4) @(posedge clk);
    end
    i_host_model.write(EMU_OFS, 8'h00);
    dedicated_charger_cycle <= 1'b1;
    wait_for(4'h8, 16'h0005, 4000);
    expect_out(4'h8, 16'h0005);
    dedicated_charger_cycle <= 1'b0;
    i_host_model.write(EMU_OFS, 8'h1C);
    dedicated_charger_cycle <= 1'b1;
    wait_for(4'h7, 16'h0001, 200);
    repeat (60) @(posedge clk);
    expect_out(4'h7, 16'h0001);
    // Current seen while untimed: accepted, response stays
    charging_current_pin <= 1'b1;
    wait_for(4'h9, 16'h0000, 20);
    expect_out(4'h9, 16'h0000);
    expect_out(4'h7, 16'h0001);
    dedicated_charger_cycle <= 1'b0;
    i_host_model.write(EMU_OFS, 8'h0C);
    charging_current_pin <= 1'b1;
    dedicated_charger_cycle <= 1'b1;
    wait_for(4'h7, 16'h0001, 200);
    repeat (60) @(posedge clk);
    expect_out(4'h7, 16'h0001);
    i_host_model.write(HSW_OFS, 8'h01);
    expect_out(4'hD, 16'h0001);
    thermal_regulation_flag_event <= 1'b1;
    @(posedge clk);
    thermal_regulation_flag_event <= 1'b0;
    expect_out(4'h7, 16'h0000);
    dedicated_charger_cycle <= 1'b0;
    i_host_model.write(EMU_OFS, 8'h08);
    dedicated_charger_cycle <= 1'b1;
    wait_for(4'h7, 16'h0001, 200);
    wait_for(4'h7, 16'h0000, 100);
    expect_out(4'h7, 16'h0000);
    complete_run();
  end
endmodule // port_charger_config_registers_tb_top
`default_nettype wire
